// [src/pulse_output_data_path.sv]
// pulse output data path: enable, output and staged registers behind apb, trigger transfer
// assumes trigger inputs are single-cycle pulses from timer logic on pclk
`include "pulse_output_defs.svh"
`default_nettype none
module pulse_output_data_path (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] timer_trigger,
  output logic [15:0] pulse_out
);
  import pulse_output_pkg::*;

  pulse_output_pkg::byte_t next_data_enable_high_r;
  pulse_output_pkg::byte_t next_data_enable_low_r;
  pulse_output_pkg::byte_t pulse_output_data_high_r;
  pulse_output_pkg::byte_t pulse_output_data_low_r;
  pulse_output_pkg::byte_t staged_data_high_r;
  pulse_output_pkg::byte_t staged_data_low_r;
  pulse_output_pkg::byte_t output_trigger_control_r;
  logic [31:0] prdata_r;
  logic wr;
  logic rd;
  logic known;
  logic trig_h3;
  logic trig_h2;
  logic trig_l1;
  logic trig_l0;
  logic split_hi;
  logic split_lo;
  pulse_output_pkg::byte_t wb;
  pulse_output_pkg::byte_t mask_h;
  pulse_output_pkg::byte_t mask_l;

  // selected trigger: one of four timer channels
  function automatic logic pick(input logic [3:0] t, input pulse_output_pkg::trig_sel_t s);
    pick = t[s];
  endfunction

  // byte update keeps bits outside the write mask
  function automatic pulse_output_pkg::byte_t merge(input pulse_output_pkg::byte_t old,
      input pulse_output_pkg::byte_t val, input pulse_output_pkg::byte_t m);
    merge = (old & ~m) | (val & m);
  endfunction

  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && !pwrite;
  assign wb = pwdata[7:0];
  assign pready = 1'b1;
  assign known = (paddr == `ENABLE_HIGH_OFFSET) || (paddr == `ENABLE_LOW_OFFSET) ||
                 (paddr == `OUTPUT_HIGH_OFFSET) || (paddr == `OUTPUT_LOW_OFFSET) ||
                 (paddr == `STAGED_HIGH_OFFSET) || (paddr == `STAGED_LOW_OFFSET) ||
                 (paddr == `STAGED_HIGH_UPPER_OFFSET) || (paddr == `STAGED_HIGH_LOWER_OFFSET) ||
                 (paddr == `STAGED_LOW_UPPER_OFFSET) || (paddr == `STAGED_LOW_LOWER_OFFSET) ||
                 (paddr == `TRIGGER_CONTROL_OFFSET);
  assign pslverr = psel && penable && !known;

  // group 3 and group 2 each select their own source, so nibbles run apart or together
  assign trig_h3 = pick(timer_trigger, output_trigger_control_r[`GROUP_HI_SEL_LSB +: 2]);
  assign trig_h2 = pick(timer_trigger, output_trigger_control_r[`GROUP_LO_SEL_LSB +: 2]);
  // low byte has no documented pins; it shares the same group selects
  assign trig_l1 = trig_h3;
  assign trig_l0 = trig_h2;
  assign split_hi = output_trigger_control_r[`GROUP_HI_SEL_LSB +: 2] !=
                    output_trigger_control_r[`GROUP_LO_SEL_LSB +: 2];
  assign split_lo = split_hi;

  // cpu may touch only disabled data bits
  assign mask_h = ~next_data_enable_high_r;
  assign mask_l = ~next_data_enable_low_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_data_enable_high_r <= `REG_RESET;
      next_data_enable_low_r <= `REG_RESET;
    end else if (wr) begin
      if (paddr == `ENABLE_HIGH_OFFSET) begin
        next_data_enable_high_r <= wb;
      end
      if (paddr == `ENABLE_LOW_OFFSET) begin
        next_data_enable_low_r <= wb;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_trigger_control_r <= `TRIGGER_CONTROL_RESET;
    end else if (wr && paddr == `TRIGGER_CONTROL_OFFSET) begin
      output_trigger_control_r <= wb;
    end
  end

  // staged data: full-byte address or nibble addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      staged_data_high_r <= `REG_RESET;
      staged_data_low_r <= `REG_RESET;
    end else if (wr) begin
      case (paddr)
        `STAGED_HIGH_OFFSET: begin
          staged_data_high_r <= wb;
        end
        `STAGED_HIGH_UPPER_OFFSET: begin
          staged_data_high_r[7:4] <= wb[7:4];
        end
        `STAGED_HIGH_LOWER_OFFSET: begin
          staged_data_high_r[3:0] <= wb[3:0];
        end
        `STAGED_LOW_OFFSET: begin
          staged_data_low_r <= wb;
        end
        `STAGED_LOW_UPPER_OFFSET: begin
          staged_data_low_r[7:4] <= wb[7:4];
        end
        `STAGED_LOW_LOWER_OFFSET: begin
          staged_data_low_r[3:0] <= wb[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // trigger transfer wins over a cpu write only on enabled bits, which the cpu cannot touch anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_output_data_high_r <= `REG_RESET;
    end else begin
      pulse_output_data_high_r <= merge(
        merge(
          merge(pulse_output_data_high_r, wb, (wr && paddr == `OUTPUT_HIGH_OFFSET) ? mask_h : 8'h00),
          staged_data_high_r, {next_data_enable_high_r[7:4] & {4{trig_h3}}, 4'h0}),
        staged_data_high_r, {4'h0, next_data_enable_high_r[3:0] & {4{trig_h2}}});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_output_data_low_r <= `REG_RESET;
    end else begin
      pulse_output_data_low_r <= merge(
        merge(
          merge(pulse_output_data_low_r, wb, (wr && paddr == `OUTPUT_LOW_OFFSET) ? mask_l : 8'h00),
          staged_data_low_r, {next_data_enable_low_r[7:4] & {4{trig_l1}}, 4'h0}),
        staged_data_low_r, {4'h0, next_data_enable_low_r[3:0] & {4{trig_l0}}});
    end
  end

  // pins 15..8 from the high data byte; 7..0 carry the low byte for internal use
  assign pulse_out = {pulse_output_data_high_r, pulse_output_data_low_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `ENABLE_HIGH_OFFSET: begin
          prdata_r <= {24'h0, next_data_enable_high_r};
        end
        `ENABLE_LOW_OFFSET: begin
          prdata_r <= {24'h0, next_data_enable_low_r};
        end
        `OUTPUT_HIGH_OFFSET: begin
          prdata_r <= {24'h0, pulse_output_data_high_r};
        end
        `OUTPUT_LOW_OFFSET: begin
          prdata_r <= {24'h0, pulse_output_data_low_r};
        end
        `STAGED_HIGH_OFFSET: begin
          prdata_r <= {24'h0, staged_data_high_r};
        end
        `STAGED_LOW_OFFSET: begin
          prdata_r <= {24'h0, staged_data_low_r};
        end
        `STAGED_HIGH_UPPER_OFFSET: begin
          prdata_r <= {24'h0, staged_data_high_r[7:4], `NIBBLE_FILL};
        end
        `STAGED_HIGH_LOWER_OFFSET: begin
          prdata_r <= {24'h0, `NIBBLE_FILL, staged_data_high_r[3:0]};
        end
        `STAGED_LOW_UPPER_OFFSET: begin
          prdata_r <= {24'h0, staged_data_low_r[7:4], `NIBBLE_FILL};
        end
        `STAGED_LOW_LOWER_OFFSET: begin
          prdata_r <= {24'h0, `NIBBLE_FILL, staged_data_low_r[3:0]};
        end
        `TRIGGER_CONTROL_OFFSET: begin
          prdata_r <= {24'h0, output_trigger_control_r};
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end
  assign prdata = prdata_r;

  logic unused_split;
  assign unused_split = split_lo;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TRANSFER_HI: assert property (trig_h3 && next_data_enable_high_r[5]
    |=> pulse_output_data_high_r[5] == $past(staged_data_high_r[5]))
    else $error("enabled bit missed trigger transfer");
  AST_HOLD_DISABLED: assert property (!next_data_enable_high_r[0] &&
    !(wr && paddr == `OUTPUT_HIGH_OFFSET) |=> $stable(pulse_output_data_high_r[0]))
    else $error("disabled bit changed without cpu write");
  AST_CPU_BLOCKED: assert property (wr && paddr == `OUTPUT_LOW_OFFSET && next_data_enable_low_r[0] &&
    !trig_l0 |=> $stable(pulse_output_data_low_r[0]))
    else $error("cpu write reached enabled bit");
  AST_CPU_PRESET: assert property (wr && paddr == `OUTPUT_HIGH_OFFSET && !next_data_enable_high_r[1]
    |=> pulse_output_data_high_r[1] == $past(pwdata[1]))
    else $error("cpu preset lost");
  AST_GROUP_INDEP: assert property (trig_h3 && !trig_h2 && !(wr && paddr == `OUTPUT_HIGH_OFFSET)
    |=> pulse_output_data_high_r[3:0] == $past(pulse_output_data_high_r[3:0]))
    else $error("lower group moved on upper trigger");
  AST_PINS: assert property (pulse_out[15:8] == pulse_output_data_high_r)
    else $error("pins do not follow data");
  AST_PIN_DELAY: assert property (trig_h2 && next_data_enable_high_r[2]
    |=> pulse_out[10] == $past(staged_data_high_r[2]))
    else $error("pin not updated after trigger");
  AST_NIBBLE_FILL: assert property (rd && !penable && paddr == `STAGED_HIGH_UPPER_OFFSET
    |=> prdata[3:0] == 4'hf)
    else $error("unused nibble not all ones");
  AST_ENABLE_WRITE: assert property (wr && paddr == `ENABLE_LOW_OFFSET
    |=> next_data_enable_low_r == $past(wb))
    else $error("enable write lost");
  AST_SELECT: assert property (trig_h3 == timer_trigger[output_trigger_control_r[3:2]])
    else $error("wrong trigger source");
  AST_RESET_ZERO: assert property ($rose(presetn) |-> next_data_enable_high_r == 8'h00)
    else $error("register not zero after reset");
  AST_RESET_ZERO_ALL: assert property ($rose(presetn) |-> next_data_enable_low_r == 8'h00 &&
    pulse_output_data_high_r == 8'h00 && pulse_output_data_low_r == 8'h00)
    else $error("data or enable register not zero after reset");
  AST_PRDATA_UPPER_ZERO: assert property (prdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");

  AST_TRANSFER_HI_NIB: assert property (trig_h2 && next_data_enable_high_r[3]
    |=> pulse_output_data_high_r[3] == $past(staged_data_high_r[3]))
    else $error("lower group bit missed trigger transfer");
  AST_TRANSFER_HI_BIT4: assert property (trig_h3 && next_data_enable_high_r[4]
    |=> pulse_output_data_high_r[4] == $past(staged_data_high_r[4]))
    else $error("upper group bit missed trigger transfer");
  AST_TRANSFER_LO_UP: assert property (trig_l1 && next_data_enable_low_r[7]
    |=> pulse_output_data_low_r[7] == $past(staged_data_low_r[7]))
    else $error("low byte upper bit missed trigger transfer");
  AST_TRANSFER_LO_LOW: assert property (trig_l0 && next_data_enable_low_r[0]
    |=> pulse_output_data_low_r[0] == $past(staged_data_low_r[0]))
    else $error("low byte lower bit missed trigger transfer");
  AST_STAGED_FULL_WRITE: assert property (wr && paddr == `STAGED_HIGH_OFFSET
    |=> staged_data_high_r == $past(wb))
    else $error("staged byte write lost");

  AST_HOLD_DISABLED_LOW: assert property (!next_data_enable_low_r[1] &&
    !(wr && paddr == `OUTPUT_LOW_OFFSET) |=> $stable(pulse_output_data_low_r[1]))
    else $error("disabled low bit changed without cpu write");
  AST_HOLD_DISABLED_UP: assert property (!next_data_enable_high_r[7] &&
    !(wr && paddr == `OUTPUT_HIGH_OFFSET) |=> $stable(pulse_output_data_high_r[7]))
    else $error("disabled upper bit changed without cpu write");
  AST_HOLD_DISABLED_LOW_NIB: assert property (!next_data_enable_low_r[4] &&
    !(wr && paddr == `OUTPUT_LOW_OFFSET) |=> $stable(pulse_output_data_low_r[4]))
    else $error("disabled low byte bit changed without cpu write");

  AST_CPU_BLOCKED_HI: assert property (wr && paddr == `OUTPUT_HIGH_OFFSET && next_data_enable_high_r[5] &&
    !trig_h3 |=> $stable(pulse_output_data_high_r[5]))
    else $error("cpu write reached enabled high bit");
  AST_HOLD_ENABLED_HI: assert property (next_data_enable_high_r[4] && !trig_h3
    |=> $stable(pulse_output_data_high_r[4]))
    else $error("enabled high bit moved without trigger");
  AST_HOLD_ENABLED_LO: assert property (next_data_enable_low_r[7] && !trig_l1
    |=> $stable(pulse_output_data_low_r[7]))
    else $error("enabled low bit moved without trigger");

  AST_CPU_PRESET_LOW: assert property (wr && paddr == `OUTPUT_LOW_OFFSET && !next_data_enable_low_r[3]
    |=> pulse_output_data_low_r[3] == $past(pwdata[3]))
    else $error("cpu preset of low byte lost");
  AST_CPU_PRESET_UP: assert property (wr && paddr == `OUTPUT_HIGH_OFFSET && !next_data_enable_high_r[6]
    |=> pulse_output_data_high_r[6] == $past(pwdata[6]))
    else $error("cpu preset of upper bit lost");
  AST_READ_DATA_HI: assert property (rd && !penable && paddr == `OUTPUT_HIGH_OFFSET
    |=> prdata[7:0] == $past(pulse_output_data_high_r))
    else $error("output data read back wrong");

  AST_GROUP_INDEP_UP: assert property (trig_h2 && !trig_h3 && !(wr && paddr == `OUTPUT_HIGH_OFFSET)
    |=> pulse_output_data_high_r[7:4] == $past(pulse_output_data_high_r[7:4]))
    else $error("upper group moved on lower trigger");
  AST_GROUP_INDEP_LOW: assert property (trig_l1 && !trig_l0 && !(wr && paddr == `OUTPUT_LOW_OFFSET)
    |=> pulse_output_data_low_r[3:0] == $past(pulse_output_data_low_r[3:0]))
    else $error("low byte lower nibble moved on upper trigger");

  AST_ENABLE_WRITE_HI: assert property (wr && paddr == `ENABLE_HIGH_OFFSET
    |=> next_data_enable_high_r == $past(wb))
    else $error("high enable write lost");
  AST_ENABLE_KEEP_LO: assert property (!(wr && paddr == `ENABLE_LOW_OFFSET)
    |=> $stable(next_data_enable_low_r))
    else $error("low enable changed without write");
  AST_ENABLE_KEEP_HI: assert property (!(wr && paddr == `ENABLE_HIGH_OFFSET)
    |=> $stable(next_data_enable_high_r))
    else $error("high enable changed without write");
  AST_READ_ENABLE: assert property (rd && !penable && paddr == `ENABLE_LOW_OFFSET
    |=> prdata[7:0] == $past(next_data_enable_low_r))
    else $error("enable read back wrong");

  AST_UNSELECTED_QUIET_HI: assert property (!trig_h3 && !trig_h2 && !(wr && paddr == `OUTPUT_HIGH_OFFSET)
    |=> $stable(pulse_output_data_high_r))
    else $error("high data moved on an unselected trigger");
  AST_UNSELECTED_QUIET_LO: assert property (!trig_l1 && !trig_l0 && !(wr && paddr == `OUTPUT_LOW_OFFSET)
    |=> $stable(pulse_output_data_low_r))
    else $error("low data moved on an unselected trigger");
  AST_CTRL_WRITE: assert property (wr && paddr == `TRIGGER_CONTROL_OFFSET
    |=> output_trigger_control_r == $past(wb))
    else $error("trigger control write lost");

  AST_NIBBLE_FILL_LO: assert property (rd && !penable && paddr == `STAGED_HIGH_LOWER_OFFSET
    |=> prdata[7:4] == 4'hf)
    else $error("unused upper nibble not all ones");
  AST_STAGED_NIBBLE: assert property (wr && paddr == `STAGED_LOW_LOWER_OFFSET
    |=> staged_data_low_r == {$past(staged_data_low_r[7:4]), $past(wb[3:0])})
    else $error("nibble write touched the other nibble");

  AST_PINS_LOW: assert property (pulse_out[7:0] == pulse_output_data_low_r)
    else $error("low pins do not follow data");
  AST_PIN_LOW_DELAY: assert property (trig_l0 && next_data_enable_low_r[0]
    |=> pulse_out[0] == $past(staged_data_low_r[0]))
    else $error("low pin not updated after trigger");

  COV_TRANSFER: cover property (trig_h3 && next_data_enable_high_r[5]);
  COV_PRESET: cover property (wr && paddr == `OUTPUT_HIGH_OFFSET && !next_data_enable_high_r[0]);
  COV_SPLIT: cover property (split_hi && trig_h2);
  COV_BLOCKED: cover property (wr && paddr == `OUTPUT_LOW_OFFSET && next_data_enable_low_r != 8'h00);
  COV_NIBBLE: cover property (wr && paddr == `STAGED_LOW_LOWER_OFFSET);
endmodule
`default_nettype wire

// [pkg/pulse_output_defs.svh]
// constants of the pulse output data path: offsets, field positions, reset values
// assumes an apb slave with 32-bit data and byte addresses on paddr
// Behaviour
// - two four-bit groups run independently or together
// - upper group drives outs 15..12, lower 11..8
// - enabled bit takes staged bit on trigger
// - disabled bit keeps its value on trigger
// - cpu writes ignored on enabled output bits
// - cpu writes accepted on disabled output bits
// - eight-bit enable and data registers reset zero
// - each bit position enabled individually
// - each group uses its selected trigger source
// - split triggers give nibble addresses, unused ones
`ifndef PULSE_OUTPUT_DEFS_SVH
`define PULSE_OUTPUT_DEFS_SVH
`define ENABLE_HIGH_OFFSET 12'h000
`define ENABLE_LOW_OFFSET 12'h004
`define OUTPUT_HIGH_OFFSET 12'h008
`define OUTPUT_LOW_OFFSET 12'h00c
`define STAGED_HIGH_OFFSET 12'h010
`define STAGED_LOW_OFFSET 12'h014
`define STAGED_HIGH_UPPER_OFFSET 12'h018
`define STAGED_HIGH_LOWER_OFFSET 12'h01c
`define STAGED_LOW_UPPER_OFFSET 12'h020
`define STAGED_LOW_LOWER_OFFSET 12'h024
`define TRIGGER_CONTROL_OFFSET 12'h028
`define REG_RESET 8'h00
`define TRIGGER_CONTROL_RESET 8'h00
`define NIBBLE_FILL 4'hf
`define GROUP_HI_SEL_LSB 2
`define GROUP_LO_SEL_LSB 0
`endif

// [pkg/pulse_output_pkg.sv]
// types of the pulse output data path
// assumes the defs header sits beside it
package pulse_output_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] nibble_t;
  typedef logic [1:0] trig_sel_t;
endpackage

// [testbench/timer_model.sv]
// timer unit model: one-cycle trigger pulse on a requested channel
// assumes pclk and presetn are shared with the data path
`default_nettype none
module timer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] ch,
  input wire logic slow,
  output logic [3:0] timer_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r;
  logic [1:0] ch_r;
  // slow answers leave a few idle cycles so the path must not act early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      ch_r <= 2'h0;
      timer_trigger <= 4'h0;
    end else begin
      timer_trigger <= 4'h0;
      if (go) begin
        cnt_r <= slow ? 3'h4 : 3'h1;
        ch_r <= ch;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
        if (cnt_r == 3'h1) begin
          timer_trigger[ch_r] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_pulse_output_data_path.sv]
// bench: apb register access plus timer triggers, expectations kept locally
// assumes the data path, its defs header and the timer model
`include "pulse_output_defs.svh"
`default_nettype none
module tb_pulse_output_data_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0, pready, pslverr, err;
  logic [11:0] paddr = 0, off;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0, trig;
  logic [1:0] chn = 0, sel_hi = 0, sel_lo = 0;
  logic [15:0] pulse_out;
  logic [7:0] en[2], output_level_bit[2], stg[2];
  int fails = 0, n_tests = 0, i;
  always #10 pclk = ~pclk;
  pulse_output_data_path uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_trigger(trig), .pulse_out(pulse_out));
  timer_model tmr (.pclk(pclk), .presetn(presetn), .go(go), .ch(chn), .slow(slow), .timer_trigger(trig));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1;
    // only the watchdog ends a stuck wait
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  task fire(input logic [1:0] c, input logic s);
    logic [7:0] m;
    int j;
    m = (c == sel_hi ? 8'hf0 : 8'h00) | (c == sel_lo ? 8'h0f : 8'h00);
    @(posedge pclk);
    go <= 1; chn <= c; slow <= s;
    @(posedge pclk);
    go <= 0;
    do begin @(negedge pclk); end while (trig[c] !== 1'b1);
    @(negedge pclk);
    for (j = 0; j < 2; j++) output_level_bit[j] = (output_level_bit[j] & ~(en[j] & m)) | (stg[j] & en[j] & m);
    check("pins", {16'h0, pulse_out}, {16'h0, output_level_bit[0], output_level_bit[1]});
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    results;
  end
  initial begin
    output_level_bit = '{8'ha5, 8'h3c};
    en = '{8'h3c, 8'h81};
    stg = '{8'h5a, 8'h7e};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 4; i++) rdchk("reset", 12'(4 * i), 32'h0);
    check("pins", {16'h0, pulse_out}, 32'h0);
    apb(1'b0, 12'h02c, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
    // preset levels first: once enabled those bits can no longer be written
    for (i = 0; i < 2; i++) begin
      off = 12'(4 * i);
      apb(1'b1, `OUTPUT_HIGH_OFFSET + off, {24'h0, output_level_bit[i]});
      rdchk("data", `OUTPUT_HIGH_OFFSET + off, {24'h0, output_level_bit[i]});
      apb(1'b1, `ENABLE_HIGH_OFFSET + off, {24'h0, en[i]});
      rdchk("enable", `ENABLE_HIGH_OFFSET + off, {24'h0, en[i]});
      apb(1'b1, `STAGED_HIGH_OFFSET + off, {24'h0, stg[i]});
      rdchk("nib_up", `STAGED_HIGH_UPPER_OFFSET + 2 * off, {24'h0, stg[i][7:4], 4'hf});
      rdchk("nib_lo", `STAGED_HIGH_LOWER_OFFSET + 2 * off, {24'h0, 4'hf, stg[i][3:0]});
    end
    check("pins", {16'h0, pulse_out}, {16'h0, output_level_bit[0], output_level_bit[1]});
    $display("test preset done");
    apb(1'b1, `TRIGGER_CONTROL_OFFSET, 32'h9);
    sel_hi = 2;
    sel_lo = 1;
    fire(2'd2, 1'b0);
    fire(2'd1, 1'b1);
    fire(2'd3, 1'b0);
    fire(2'd0, 1'b1);
    $display("test split triggers done");
    apb(1'b1, `OUTPUT_HIGH_OFFSET, 32'hff);
    apb(1'b1, `OUTPUT_LOW_OFFSET, 32'h0);
    output_level_bit[0] = (output_level_bit[0] & en[0]) | (8'hff & ~en[0]);
    output_level_bit[1] = output_level_bit[1] & en[1];
    rdchk("data_h", `OUTPUT_HIGH_OFFSET, {24'h0, output_level_bit[0]});
    rdchk("data_l", `OUTPUT_LOW_OFFSET, {24'h0, output_level_bit[1]});
    $display("test protected writes done");
    apb(1'b1, `TRIGGER_CONTROL_OFFSET, 32'h5);
    sel_hi = 1;
    apb(1'b1, `STAGED_HIGH_OFFSET, 32'hc3);
    stg[0] = 8'hc3;
    apb(1'b1, `STAGED_LOW_LOWER_OFFSET, 32'h5);
    stg[1][3:0] = 4'h5;
    rdchk("staged_l", `STAGED_LOW_OFFSET, {24'h0, stg[1]});
    fire(2'd1, 1'b0);
    fire(2'd2, 1'b1);
    $display("test shared trigger done");
    results;
  end
endmodule
`default_nettype wire
